// ### logic/dac_front_defines.svh
// Register offsets, reset values and counts of the DAC serial front end
`ifndef DAC_FRONT_DEFINES_SVH
`define DAC_FRONT_DEFINES_SVH
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_INT_STAT  8'h08
`define REG_INT_MASK  8'h0C
`define REG_LEFT      8'h10
`define REG_RIGHT     8'h14
`define CTRL_RESET    5'h00
`define ZERO_RUN      13'h1000
`define WORD_BITS     5'h12
`define SHORT_BITS    5'h10
`define NUM_EVENTS    3
`endif

// ### logic/dac_front_pkg.sv
// Types shared by the DAC serial front end
package dac_front_pkg;
    // Serial formats in select-code order 00..11
    typedef enum logic [1:0] {FMT_RJ16, FMT_RJ18, FMT_LJ, FMT_I2S} fmt_t;
    // Control register layout, bit 0 upward: run, mute_en, fmt, ratio
    typedef struct packed {
        logic ratio;
        fmt_t fmt;
        logic mute_en;
        logic run;
    } ctrl_t;
    // Captured AHB address phase
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
    } ahb_req_t;
endpackage

// ### logic/stereo_dac_front.sv
// Serial input, zero detect, mute and 1-bit outputs of a stereo DAC
// Notes on behaviour
// (R1) Mute enabled: mute after 4096 zero samples
// (R2) Mute disabled: zero data never mutes
// (R3) Zero flag after 4096 zero word cycles
// (R4) Clock out is always 256x word rate
// (R5) Ratio select low 256x, high 384x
// (R6) Word clock level picks the channel
// (R7) Bits shift on format-chosen bit-clock edge
// (R8) Source sends MSB-first 16/18-bit words
// (R9) Format code sets word/bit clock alignment
// (R10) Run low holds filters and modulators
// (R11) Factory test inputs tied to ground
// (R12) Each channel drives complementary pair
// (R13) Codes: 16-bit, 18-bit, left-justified, I2S
// (R14) Rising edge except left-justified: falling
// (R15) Mute releases at once when cause goes
// (R16) Reset zeroes outputs, realigns word timing
// (R17) Nonzero sample restarts zero run count
// (R18) Zero cycle needs both channels zero
`include "dac_front_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module stereo_dac_front
    import dac_front_pkg::*;
(
    input  wire logic        CLOCK,                    // 200 MHz
    input  wire logic        RST,                      // Async, high
    input  wire logic        HSEL,                     // Slave select
    input  wire logic [31:0] HADDR,                    // Byte address
    input  wire logic [1:0]  HTRANS,                   // Transfer type
    input  wire logic        HWRITE,                   // Write
    input  wire logic [2:0]  HSIZE,                    // Word only
    input  wire logic [31:0] HWDATA,                   // Write data
    input  wire logic        HREADY,                   // Bus ready
    output logic             HREADYOUT,                // Always ready
    output logic [31:0]      HRDATA,                   // Read data
    output logic             HRESP,                    // Always OKAY
    input  wire logic        MASTER_CLOCK_IN,          // 256x/384x clock
    input  wire logic        SERIAL_BIT_CLOCK,         // Bit clock
    input  wire logic        CHANNEL_WORD_CLOCK,       // Word clock
    input  wire logic        SERIAL_SAMPLE_IN,         // Serial data
    output logic             OSCILLATOR_DRIVE_OUT,     // Inverted master
    output logic             WORD_RATE_X256_CLOCK_OUT, // 256x word rate
    output logic             ZERO_DATA_FLAG,           // Zero run seen
    output logic             LEFT_OUT_POS,             // Left true
    output logic             LEFT_OUT_NEG,             // Left complement
    output logic             RIGHT_OUT_POS,            // Right true
    output logic             RIGHT_OUT_NEG,            // Right complement
    output logic             IRQ                       // Level interrupt
);
    localparam int N_EV = `NUM_EVENTS;

    ctrl_t                  ctrl_ff;
    ahb_req_t               req_ff;
    logic                   pend_ff;
    logic [3:0]             s1_ff;
    logic [3:0]             s2_ff;
    logic [3:0]             s3_ff;
    logic [1:0]             ecnt_ff;
    logic                   sck_ff;
    logic [17:0]            sh_ff;
    logic [4:0]             nbit_ff;
    logic [4:0]             cap_ff;
    logic                   lr_last_ff;
    logic [17:0]            left_ff;
    logic [17:0]            right_ff;
    logic                   done_ff;
    logic                   done_left_ff;
    logic [12:0]            zcnt_ff;
    logic                   zflag_ff;
    logic                   mute_ff;
    logic [N_EV-1:0]        int_ff;
    logic [N_EV-1:0]        mask_ff;
    logic [1:0]             pos_ff;
    logic [1:0]             neg_ff;
    logic                   run;
    logic                   m_edge;
    logic                   b_rise;
    logic                   b_fall;
    logic                   act;
    logic                   lr;
    logic                   lr_chg;
    logic                   take;
    logic [4:0]             skip;
    logic                   is_rj;
    logic [17:0]            word;
    logic                   wr_go;
    logic [N_EV-1:0]        ev;
    logic [N_EV-1:0]        clr;
    logic [31:0]            nxt_rdata;

    assign run    = ctrl_ff.run;
    assign m_edge = s2_ff[0] ^ s3_ff[0];
    assign b_rise = s2_ff[1] & ~s3_ff[1];
    assign b_fall = ~s2_ff[1] & s3_ff[1];
    assign lr     = s2_ff[2];
    assign is_rj  = (ctrl_ff.fmt == FMT_RJ16) || (ctrl_ff.fmt == FMT_RJ18);
    assign act    = (ctrl_ff.fmt == FMT_LJ) ? b_fall : b_rise; // see (R7) (R14)
    assign lr_chg = act && (lr != lr_last_ff);
    // I2S puts one dead bit between the word clock edge and the MSB
    assign skip   = (ctrl_ff.fmt == FMT_I2S) ? 5'h01 : 5'h00;  // see (R9) (R13)
    assign take   = is_rj || ((lr_chg ? 5'h00 : nbit_ff) >= skip
                    && (lr_chg ? 5'h00 : nbit_ff) < skip + `WORD_BITS);

    // Finished word, left aligned to 18 bits whatever its length
    always_comb begin
        case (ctrl_ff.fmt)
            FMT_RJ16: word = {sh_ff[15:0], 2'h0};       // see (R13)
            FMT_RJ18: word = sh_ff;
            default:  word = sh_ff << (`WORD_BITS - cap_ff);
        endcase
    end

    // Two-stage synchronisers for the pins from the source's domain
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            s1_ff <= 4'h0;
            s2_ff <= 4'h0;
            s3_ff <= 4'h0;
        end else begin
            s1_ff <= {SERIAL_SAMPLE_IN, CHANNEL_WORD_CLOCK,
                      SERIAL_BIT_CLOCK, MASTER_CLOCK_IN};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // 256x clock out: 384x input drops every third master edge
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ecnt_ff              <= 2'h0;
            sck_ff               <= 1'b0;
            OSCILLATOR_DRIVE_OUT <= 1'b1;
        end else begin
            OSCILLATOR_DRIVE_OUT <= ~s2_ff[0];
            if (m_edge) begin
                ecnt_ff <= (ecnt_ff == 2'h2) ? 2'h0 : ecnt_ff + 2'h1;
                if (!ctrl_ff.ratio || ecnt_ff != 2'h2) begin // see (R4) (R5)
                    sck_ff <= ~sck_ff;
                end
            end
        end
    end
    assign WORD_RATE_X256_CLOCK_OUT = sck_ff;

    // Serial shifter; held and realigned to the word clock while not running
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sh_ff      <= 18'h0;
            nbit_ff    <= 5'h0;
            cap_ff     <= 5'h0;
            lr_last_ff <= 1'b0;
        end else if (!run) begin
            sh_ff      <= 18'h0;                     // see (R10) (R16)
            nbit_ff    <= 5'h0;
            cap_ff     <= 5'h0;
            lr_last_ff <= lr;                        // see (R16)
        end else if (act) begin
            lr_last_ff <= lr;
            if (lr_chg) begin
                sh_ff   <= is_rj ? {sh_ff[16:0], s2_ff[3]}
                                 : {17'h0, s2_ff[3] & take};
                nbit_ff <= 5'h1;
                cap_ff  <= (take && !is_rj) ? 5'h1 : 5'h0;
            end else begin
                if (take) begin
                    sh_ff <= {sh_ff[16:0], s2_ff[3]};
                end
                if (nbit_ff != 5'h1F) begin
                    nbit_ff <= nbit_ff + 5'h1;
                end
                if (take && !is_rj && cap_ff != `WORD_BITS) begin
                    cap_ff <= cap_ff + 5'h1;
                end
            end
        end
    end

    // Word store; the word clock level before the change names the channel
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            left_ff      <= 18'h0;
            right_ff     <= 18'h0;
            done_ff      <= 1'b0;
            done_left_ff <= 1'b0;
        end else begin
            done_ff <= run && lr_chg;
            if (run && lr_chg) begin
                done_left_ff <= (ctrl_ff.fmt == FMT_I2S) ? ~lr_last_ff
                                                          : lr_last_ff; // see (R6)
                if ((ctrl_ff.fmt == FMT_I2S) ? ~lr_last_ff : lr_last_ff) begin
                    left_ff <= word;
                end else begin
                    right_ff <= word;
                end
            end
        end
    end

    // Zero run: a cycle counts once the right word closes a zero pair
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            zcnt_ff  <= 13'h0;
            zflag_ff <= 1'b0;
        end else if (!run) begin
            zcnt_ff  <= 13'h0;
            zflag_ff <= 1'b0;
        end else if (done_ff) begin
            if ((done_left_ff ? left_ff : right_ff) != 18'h0) begin
                zcnt_ff  <= 13'h0;                   // see (R17)
                zflag_ff <= 1'b0;
            end else if (!done_left_ff && left_ff == 18'h0) begin // see (R18)
                if (zcnt_ff != `ZERO_RUN) begin
                    zcnt_ff <= zcnt_ff + 13'h1;
                end
                if (zcnt_ff >= `ZERO_RUN - 13'h1) begin
                    zflag_ff <= 1'b1;                // see (R3)
                end
            end
        end
    end
    assign ZERO_DATA_FLAG = zflag_ff;

    // Mute follows flag and enable directly, so it drops at once
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            mute_ff <= 1'b0;
        end else begin
            mute_ff <= run && ctrl_ff.mute_en && zflag_ff; // see (R1) (R2) (R15)
        end
    end

    // First-order 1-bit modulator per channel as a stand-in for the real one
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_mod
            logic [17:0] acc_ff;
            logic [18:0] sum;
            logic [17:0] smp;
            assign smp = (ch == 0) ? left_ff : right_ff;
            // Offset binary keeps the carry density proportional to level
            assign sum = {1'b0, acc_ff} + {1'b0, ~smp[17], smp[16:0]};
            always_ff @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    acc_ff     <= 18'h0;
                    pos_ff[ch] <= 1'b0;
                    neg_ff[ch] <= 1'b0;
                end else if (!run || mute_ff) begin
                    acc_ff     <= 18'h0;             // see (R10)
                    pos_ff[ch] <= 1'b0;              // see (R16) (R1)
                    neg_ff[ch] <= 1'b0;
                end else begin
                    acc_ff     <= sum[17:0];
                    pos_ff[ch] <= sum[18];           // see (R12)
                    neg_ff[ch] <= ~sum[18];
                end
            end
        end
    endgenerate
    assign LEFT_OUT_POS  = pos_ff[0];
    assign LEFT_OUT_NEG  = neg_ff[0];
    assign RIGHT_OUT_POS = pos_ff[1];
    assign RIGHT_OUT_NEG = neg_ff[1];

    // AHB-Lite: address phase captured, write lands in the data phase
    assign wr_go = pend_ff && req_ff.wr;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pend_ff   <= 1'b0;
            req_ff    <= '0;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            HRDATA    <= 32'h0;
        end else begin
            pend_ff <= HSEL && HTRANS[1] && HREADY;
            if (HSEL && HTRANS[1] && HREADY) begin
                req_ff <= '{wr: HWRITE, addr: HADDR[7:0]};
                HRDATA <= nxt_rdata;
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (HADDR[7:0])
            `REG_CTRL:     nxt_rdata = {27'h0, ctrl_ff};
            `REG_STATUS:   nxt_rdata = {30'h0, mute_ff, zflag_ff};
            `REG_INT_STAT: nxt_rdata = {29'h0, int_ff};
            `REG_INT_MASK: nxt_rdata = {29'h0, mask_ff};
            `REG_LEFT:     nxt_rdata = {14'h0, left_ff};
            `REG_RIGHT:    nxt_rdata = {14'h0, right_ff};
            default:       nxt_rdata = 32'h0;
        endcase
    end

    // Control and mask writes
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ctrl_ff <= `CTRL_RESET;
            mask_ff <= '0;
        end else if (wr_go && req_ff.addr == `REG_CTRL) begin
            ctrl_ff <= HWDATA[4:0];
        end else if (wr_go && req_ff.addr == `REG_INT_MASK) begin
            mask_ff <= HWDATA[N_EV-1:0];
        end
    end

    // Events: zero count at 4095 on any finished word, stereo pair done, mute engaged; set beats clear
    assign ev  = {run && ctrl_ff.mute_en && zflag_ff && !mute_ff,
                  done_ff && !done_left_ff,
                  run && done_ff && zcnt_ff == `ZERO_RUN - 13'h1 && !zflag_ff};
    assign clr = (wr_go && req_ff.addr == `REG_INT_STAT) ? HWDATA[N_EV-1:0] : '0;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            int_ff <= '0;
            IRQ    <= 1'b0;
        end else begin
            int_ff <= (int_ff & ~clr) | ev;
            IRQ    <= |(int_ff & mask_ff);
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence s_zero_pair;
        done_ff && !done_left_ff && left_ff == 18'h0 && right_ff == 18'h0;
    endsequence
    sequence s_quiet_out;
        ##2 !LEFT_OUT_POS && !LEFT_OUT_NEG && !RIGHT_OUT_POS && !RIGHT_OUT_NEG;
    endsequence

    a_mute_engage: assert property (run && ctrl_ff.mute_en && zflag_ff // see (R1)
        |-> s_quiet_out) else $error("Outputs not muted after zero run");
    a_mute_never: assert property (!ctrl_ff.mute_en |=> !mute_ff) // see (R2)
        else $error("Muted with mute disabled");
    a_flag_count: assert property (s_zero_pair ##0 (zcnt_ff == `ZERO_RUN - 13'h1) // see (R3)
        |=> zflag_ff && zcnt_ff == `ZERO_RUN) else $error("Zero flag late");
    a_flag_early: assert property ($rose(zflag_ff) |-> $past(zcnt_ff) == 13'hFFF) // see (R3)
        else $error("Zero flag early");
    a_clock_drop: assert property (m_edge && ctrl_ff.ratio && ecnt_ff == 2'h2 // see (R4)
        |=> $stable(sck_ff)) else $error("384x edge not dropped");
    a_clock_pass: assert property (m_edge && (!ctrl_ff.ratio || ecnt_ff != 2'h2) // see (R4)
        |=> sck_ff != $past(sck_ff)) else $error("Clock out missed edge");
    a_pair_diff: assert property (LEFT_OUT_POS || LEFT_OUT_NEG // see (R12)
        |-> LEFT_OUT_POS != LEFT_OUT_NEG) else $error("Left pair not complementary");
    // Checked at once: a run bit written at this edge may legally wake the outputs two cycles on
    a_hold_zero: assert property (!run [*2] |-> !LEFT_OUT_POS && !LEFT_OUT_NEG // see (R16)
        && !RIGHT_OUT_POS && !RIGHT_OUT_NEG && nbit_ff == 5'h0)
        else $error("Outputs live in reset");
    a_nonzero_clr: assert property (done_ff && (done_left_ff ? left_ff : right_ff) != 18'h0 // see (R17)
        |=> !zflag_ff && zcnt_ff == 13'h0) else $error("Zero run not restarted");
    a_unmute: assert property (mute_ff && !ctrl_ff.mute_en |=> !mute_ff) // see (R15)
        else $error("Mute release late");
endmodule
`default_nettype wire

// ### sim/audio_source.sv
// Behavioural serial audio source that feeds the DAC front end
`timescale 1ns/1ps
`default_nettype none
module audio_source
    import dac_front_pkg::*;
(
    input  wire logic [1:0] fmt,   // Format code
    input  wire logic       ratio, // 1: 384x master
    output logic            mclk,  // Master clock
    output logic            bck,   // Bit clock
    output logic            wck,   // Word clock
    output logic            sd     // Serial data
);
    int seed = 7;

    // Master clock runs free; the link clocks stand still between frames
    initial begin
        mclk = 1'b0;
        bck = 1'b1;
        wck = 1'b0;
        sd = 1'b0;
    end
    always #(ratio ? 13.333 : 20.0) mclk = ~mclk;

    // Half a bit period counted in master edges, so the link stays synchronous
    task automatic half;
        repeat (ratio ? 3 : 2) @(posedge mclk);
    endtask

    // Word bit carried by slot i, or -1 for a junk slot
    function automatic int slot_bit(input int i);
        case (fmt)
            FMT_RJ16: return (i >= 16) ? 33 - i : -1;
            FMT_RJ18: return (i >= 14) ? 31 - i : -1;
            FMT_LJ:   return (i < 18) ? 17 - i : -1;
            default:  return (i >= 1 && i <= 18) ? 18 - i : -1;
        endcase
    endfunction

    // One channel of 32 slots; junk bits fill every slot outside the word
    task automatic send_word(input logic [17:0] w, input logic lvl);
        int n;
        int junk;
        for (int i = 0; i < 32; i++) begin
            n = slot_bit(i);
            junk = $random(seed);
            wck = lvl;
            sd = (n < 0) ? junk[0] : w[n];
            bck = (fmt == FMT_LJ);
            half();
            bck = ~bck;
            half();
        end
    endtask

    // Left then right; afterwards the data line shows the inverse
    task automatic send_pair(input logic [17:0] l, input logic [17:0] r);
        send_word(l, fmt != FMT_I2S);
        send_word(r, fmt == FMT_I2S);
        sd = ~sd;
    endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench of the stereo DAC serial front end
`include "dac_front_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb
    import dac_front_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdv, rd;
    logic        hreadyout, hresp, osc, word_rate_x256_clock_out, zflag, lp, ln, rp, rn, irq, rdy;
    logic        mclk, bck, wck, sd;
    logic [1:0]  sfmt = 2'h0;
    logic        sratio = 1'b0;
    int          fails = 0;
    int          total_checks = 0;
    int          seed = 98913;
    int          omode = 0;
    logic [7:0]  ra [5] = '{`REG_CTRL, `REG_STATUS, `REG_INT_STAT, `REG_INT_MASK, 8'h20};

    // Factory test pins are not brought out, so they stay grounded
    stereo_dac_front u_dut (.CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
        .MASTER_CLOCK_IN(mclk), .SERIAL_BIT_CLOCK(bck), .CHANNEL_WORD_CLOCK(wck),
        .SERIAL_SAMPLE_IN(sd), .OSCILLATOR_DRIVE_OUT(osc),
        .WORD_RATE_X256_CLOCK_OUT(word_rate_x256_clock_out), .ZERO_DATA_FLAG(zflag), .LEFT_OUT_POS(lp),
        .LEFT_OUT_NEG(ln), .RIGHT_OUT_POS(rp), .RIGHT_OUT_NEG(rn), .IRQ(irq));
    audio_source u_src (.fmt(sfmt), .ratio(sratio), .mclk(mclk), .bck(bck), .wck(wck),
        .sd(sd));

    always #2.5 clock = ~clock;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Values are taken at the negedge, so they are those seen at the next rising edge
    task automatic wready;
        int n;
        n = 0;
        rdy = 1'b0;
        while (rdy !== 1'b1 && n < 40) begin
            @(negedge clock);
            rdy = hreadyout;
            rdv = hrdata;
            @(posedge clock);
            n++;
        end
        if (rdy !== 1'b1) begin
            fails++;
            end_sim;
        end
    endtask

    // Single word transfer; one idle cycle after it keeps read-after-write clean
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wready();
        htrans <= 2'b00;
        hwdata <= wd;
        wready();
        rd = rdv;
        hsel <= 1'b0;
        @(posedge clock);
    endtask

    function automatic logic [31:0] exp_word(input logic [1:0] f, input logic [17:0] v);
        return (f == FMT_RJ16) ? {14'h0, v[17:2], 2'b00} : {14'h0, v};
    endfunction

    function automatic logic [31:0] ctrl(input logic [1:0] f, input logic ra_, mu, run);
        ctrl_t c;
        c.ratio = ra_;
        c.fmt = fmt_t'(f);
        c.mute_en = mu;
        c.run = run;
        return {27'h0, c};
    endfunction

    // Output pairs: complementary while running, all zero while held
    always @(negedge clock) begin
        if (omode == 1) chk({30'h0, lp ^ ln, rp ^ rn}, 32'h3);
        else if (omode == 2) chk({28'h0, lp, ln, rp, rn}, 32'h0);
    end

    // A hang anywhere ends the run as a failure
    initial begin
        repeat (90000) @(posedge clock);
        fails++;
        end_sim;
    end

    initial begin
        int f, k, cnt, co;
        logic prev, po;
        logic [17:0] l, r, rprev;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // Reset values, unmapped space, reserved bits and a read-only register
        for (k = 0; k < 5; k++) begin
            bus(1'b0, ra[k], 32'h0);
            chk(rd, 32'h0);
        end
        chk({30'h0, zflag, irq}, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        bus(1'b1, `REG_CTRL, 32'hFFFF_FFE0);
        bus(1'b0, `REG_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `REG_STATUS, 32'hFFFF_FFFF);
        bus(1'b0, `REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        // Every format with random samples; the ratio flips halfway
        for (f = 0; f < 4; f++) begin
            sfmt <= f[1:0];
            sratio <= f[1];
            bus(1'b1, `REG_CTRL, ctrl(f[1:0], f[1], 1'b0, 1'b1));
            for (k = 0; k < 4; k++) begin
                l = 18'($random(seed));
                r = 18'($random(seed));
                u_src.send_pair(l, r);
                @(posedge clock);
                omode = 1;
                if (k > 0) begin
                    bus(1'b0, `REG_LEFT, 32'h0);
                    chk(rd, exp_word(f[1:0], l));
                    bus(1'b0, `REG_RIGHT, 32'h0);
                    chk(rd, exp_word(f[1:0], rprev));
                end
                rprev = r;
            end
            omode = 0;
            // One word period is 2048 system cycles: count clock-out rises in it
            // The oscillator drive follows the master clock, so it shows the ratio itself
            cnt = 0;
            co = 0;
            prev = word_rate_x256_clock_out;
            po = osc;
            for (k = 0; k < 2048; k++) begin
                @(negedge clock);
                if (word_rate_x256_clock_out === 1'b1 && prev === 1'b0) cnt++;
                if (osc === 1'b1 && po === 1'b0) co++;
                prev = word_rate_x256_clock_out;
                po = osc;
            end
            chk({31'h0, cnt >= 254 && cnt <= 258}, 32'h1);
            chk({31'h0, co >= (f[1] ? 382 : 254) && co <= (f[1] ? 386 : 258)}, 32'h1);
            @(posedge clock);
        end
        // Sticky event, masked and unmasked interrupt, write-one-to-clear
        bus(1'b0, `REG_INT_STAT, 32'h0);
        chk(rd, 32'h2);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `REG_INT_MASK, 32'h7);
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `REG_INT_STAT, 32'h2);
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, `REG_INT_MASK, 32'h0);
        chk(rd, 32'h7);
        // Run low: bits are ignored and both output pairs are held at zero
        bus(1'b1, `REG_CTRL, ctrl(2'h3, 1'b1, 1'b0, 1'b0));
        repeat (10) @(posedge clock);
        omode = 2;
        u_src.send_pair(~l, ~r);
        @(posedge clock);
        bus(1'b0, `REG_LEFT, 32'h0);
        chk(rd, exp_word(2'h3, l));
        bus(1'b0, `REG_INT_STAT, 32'h0);
        chk(rd, 32'h0);
        omode = 0;
        // Short zero run with mute on: the 4096 count is far too long for this
        // bench, so only an early flag or mute is caught here
        sfmt <= 2'h2;
        sratio <= 1'b0;
        bus(1'b1, `REG_CTRL, ctrl(2'h2, 1'b0, 1'b1, 1'b1));
        for (k = 0; k < 4; k++) begin
            u_src.send_pair(18'h0, 18'h0);
            @(posedge clock);
            omode = 1;
        end
        omode = 0;
        bus(1'b0, `REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, zflag}, 32'h0);
        bus(1'b0, `REG_RIGHT, 32'h0);
        chk(rd, 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire
